// ==== verilog/mcmc_pkg.sv ====
// Constants and mode encoding for the master clock mode control block
// Operation
// - All-ones transmit timed from reference, not transmit clock
// - Receive clock follows reference during loss of signal
// - Reference times clock recovery and jitter attenuator
// - Host wait-state logic runs from reference clock
// - Reference stuck low: receive path off, outputs tristate
// - Reference stuck high: no recovery, plain data receiver
// - Each channel clock times only its own rails
package mcmc_pkg;
  // ==========================================================
  // Geometry and timing
  localparam int NUM_CH = 8;
  localparam int CLK_PERIOD_PS = 5000;
  // No reference edge for this long means the reference is static
  localparam int STATIC_TIMEOUT_PS = 2000000;
  // Least time, rounded up to whole cycles
  localparam int STATIC_CYCLES = (STATIC_TIMEOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_W = 9;
  localparam logic [IDLE_W-1:0] IDLE_ZERO = 9'h000;
  localparam logic [IDLE_W-1:0] IDLE_ONE = 9'h001;
  localparam logic [IDLE_W-1:0] STATIC_LAST = IDLE_W'(STATIC_CYCLES - 1);
  // Reference edges a parallel host is held in wait
  localparam logic [1:0] WAIT_REF_EDGES = 2'h2;
  localparam logic [1:0] WAIT_ZERO = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;

  // ==========================================================
  // Receive path modes
  typedef enum logic [2:0] {
    MCMC_RUN  = 3'h1,
    MCMC_DOWN = 3'h2,
    MCMC_RAW  = 3'h4
  } mcmc_mode_t;
endpackage

// ==== verilog/mcmc_lane.sv ====
// One transceiver channel: receive output selection and transmit timing
`timescale 1ns/10ps
`default_nettype none
module mcmc_lane
  import mcmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_level,
  input wire logic ref_tick,
  input wire logic mode_down,
  input wire logic mode_raw,
  input wire logic los,
  input wire logic all_ones_tx_generator_en,
  input wire logic tx_clock_in,
  input wire logic line_rx_clock,
  input wire logic rec_pos,
  input wire logic rec_neg,
  input wire logic raw_pos,
  input wire logic raw_neg,
  output logic recovered_rx_clock,
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output logic rx_oe,
  output logic all_ones_tx_generator
);
  logic tx_prev;

  // ==========================================================
  // Receive outputs, fed by this channel's own sources, except the clock, which comes from the reference under loss of signal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recovered_rx_clock <= 1'b0;
      rx_positive_rail <= 1'b0;
      rx_negative_rail <= 1'b0;
      rx_oe <= 1'b0;
    end else if (mode_down) begin
      // Powered down: pins released, levels parked low
      recovered_rx_clock <= 1'b0;
      rx_positive_rail <= 1'b0;
      rx_negative_rail <= 1'b0;
      rx_oe <= 1'b0;
    end else if (mode_raw) begin
      // No recovered clock exists, sliced rails go straight out
      recovered_rx_clock <= 1'b0;
      rx_positive_rail <= raw_pos;
      rx_negative_rail <= raw_neg;
      rx_oe <= 1'b1;
    end else begin
      recovered_rx_clock <= los ? ref_level : line_rx_clock;
      rx_positive_rail <= rec_pos;
      rx_negative_rail <= rec_neg;
      rx_oe <= 1'b1;
    end
  end

  // ==========================================================
  // Transmit bit timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_prev <= 1'b0;
      all_ones_tx_generator <= 1'b0;
    end else begin
      tx_prev <= tx_clock_in;
      // The alarm pattern must not depend on a framer clock that may be gone
      all_ones_tx_generator <= all_ones_tx_generator_en ? ref_tick : (tx_clock_in & ~tx_prev);
    end
  end

  all_ones_tx_generator_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
    all_ones_tx_generator_en && !ref_tick |=> !all_ones_tx_generator)
    else $error("alarm transmit tick without reference edge");
endmodule
`default_nettype wire

// ==== verilog/mcmc_top.sv ====
// Master reference clock watch, mode select and reference-timed services
`timescale 1ns/10ps
`default_nettype none
module mcmc_top
  import mcmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_ref_clock,
  input wire logic [NUM_CH-1:0] los,
  input wire logic [NUM_CH-1:0] all_ones_tx_generator_en,
  input wire logic [NUM_CH-1:0] tx_clock_in,
  input wire logic [NUM_CH-1:0] line_rx_clock,
  input wire logic [NUM_CH-1:0] rec_pos,
  input wire logic [NUM_CH-1:0] rec_neg,
  input wire logic [NUM_CH-1:0] raw_pos,
  input wire logic [NUM_CH-1:0] raw_neg,
  input wire logic host_access_req,
  output logic [NUM_CH-1:0] recovered_rx_clock,
  output logic [NUM_CH-1:0] rx_positive_rail,
  output logic [NUM_CH-1:0] rx_negative_rail,
  output logic [NUM_CH-1:0] rx_oe,
  output logic [NUM_CH-1:0] all_ones_tx_generator,
  output logic ref_timing_tick,
  output logic clock_recovery_enable,
  output logic rx_path_powered,
  output logic host_wait_acknowledge
);
  logic ref_q;
  logic ref_prev;
  logic ref_edge;
  logic ref_rise;
  logic [IDLE_W-1:0] idle_cnt;
  mcmc_mode_t mode;
  logic [1:0] wait_cnt;
  logic req_prev;

  assign ref_edge = ref_q ^ ref_prev;
  assign ref_rise = ref_q & ~ref_prev & (mode == MCMC_RUN);

  // ==========================================================
  // Reference sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_q <= master_ref_clock;
      ref_prev <= ref_q;
    end
  end

  // ==========================================================
  // Static level watch on the internal time base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= IDLE_ZERO;
    end else if (ref_edge) begin
      idle_cnt <= IDLE_ZERO;
    end else if (idle_cnt != STATIC_LAST) begin
      idle_cnt <= idle_cnt + IDLE_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MCMC_RUN;
    end else begin
      case (mode)
        MCMC_RUN: begin
          if (!ref_edge && idle_cnt == STATIC_LAST) begin
            mode <= ref_q ? MCMC_RAW : MCMC_DOWN;
          end
        end
        MCMC_DOWN, MCMC_RAW: begin
          // A single edge is enough to resume; the recovery loop relocks on its own
          if (ref_edge) begin
            mode <= MCMC_RUN;
          end
        end
        default: begin
          mode <= MCMC_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Reference services: recovery, jitter attenuator, status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_timing_tick <= 1'b0;
      clock_recovery_enable <= 1'b0;
      rx_path_powered <= 1'b0;
    end else begin
      ref_timing_tick <= ref_rise;
      clock_recovery_enable <= (mode == MCMC_RUN);
      rx_path_powered <= (mode != MCMC_DOWN);
    end
  end

  // ==========================================================
  // Host wait states counted in reference edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_prev <= 1'b0;
      wait_cnt <= WAIT_ZERO;
      host_wait_acknowledge <= 1'b0;
    end else begin
      req_prev <= host_access_req;
      if (!host_access_req || mode != MCMC_RUN) begin
        // Without a reference no wait can be timed, so no acknowledge
        wait_cnt <= WAIT_ZERO;
        host_wait_acknowledge <= 1'b0;
      end else if (!req_prev) begin
        wait_cnt <= WAIT_ZERO;
      end else if (wait_cnt != WAIT_REF_EDGES) begin
        if (ref_rise) begin
          wait_cnt <= wait_cnt + WAIT_ONE;
        end
      end else begin
        host_wait_acknowledge <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Channels
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_lane
    mcmc_lane u_mcmc_lane (
      .clk(clk),
      .rst_n(rst_n),
      .ref_level(ref_q),
      .ref_tick(ref_rise),
      .mode_down(mode == MCMC_DOWN),
      .mode_raw(mode == MCMC_RAW),
      .los(los[ch]),
      .all_ones_tx_generator_en(all_ones_tx_generator_en[ch]),
      .tx_clock_in(tx_clock_in[ch]),
      .line_rx_clock(line_rx_clock[ch]),
      .rec_pos(rec_pos[ch]),
      .rec_neg(rec_neg[ch]),
      .raw_pos(raw_pos[ch]),
      .raw_neg(raw_neg[ch]),
      .recovered_rx_clock(recovered_rx_clock[ch]),
      .rx_positive_rail(rx_positive_rail[ch]),
      .rx_negative_rail(rx_negative_rail[ch]),
      .rx_oe(rx_oe[ch]),
      .all_ones_tx_generator(all_ones_tx_generator[ch])
    );
  end

  // ==========================================================
  // Checks
  static_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RUN && !ref_edge && idle_cnt == STATIC_LAST |=> mode != MCMC_RUN)
    else $error("static reference not declared after timeout");
  early_static_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RUN ##1 mode != MCMC_RUN |-> $past(idle_cnt) == STATIC_LAST)
    else $error("static reference declared before timeout");
  edge_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    ref_edge |=> mode == MCMC_RUN)
    else $error("reference edge did not restore run mode");
  low_tristate_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_DOWN |=> rx_oe == '0 && !rx_path_powered)
    else $error("receive pins driven while powered down");
  // The first rise is already in ref_q while the mode still reads down, so the delayed copy is checked
  low_is_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_DOWN |-> !ref_prev)
    else $error("power down with reference high");
  down_rails_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_DOWN |=> rx_positive_rail == '0 && rx_negative_rail == '0 && recovered_rx_clock == '0)
    else $error("receive levels not parked while powered down");
  raw_rails_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RAW |=> rx_positive_rail == $past(raw_pos)
      && rx_negative_rail == $past(raw_neg))
    else $error("plain receiver rails not from sliced data");
  run_status_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RUN |=> rx_path_powered && clock_recovery_enable)
    else $error("run mode without recovery or power");
  high_raw_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RAW |=> !clock_recovery_enable && recovered_rx_clock == '0 && rx_oe == '1)
    else $error("recovery active in plain receiver mode");
  los_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RUN && los[0] |=> recovered_rx_clock[0] == $past(ref_q))
    else $error("lost-signal receive clock not from reference");
  ref_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    ref_timing_tick |-> $past(ref_q) && !$past(ref_prev))
    else $error("reference tick without reference rise");
  // A static reference must not leak stray ticks into the recovery loop
  tick_run_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode != MCMC_RUN |=> !ref_timing_tick)
    else $error("reference tick outside run mode");
  idle_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ref_edge |=> idle_cnt == IDLE_ZERO)
    else $error("idle time not restarted on reference edge");
  no_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode != MCMC_RUN |=> !host_wait_acknowledge)
    else $error("wait acknowledge without reference");
  wait_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(host_wait_acknowledge) |-> $past(wait_cnt) == WAIT_REF_EDGES)
    else $error("acknowledge before wait edges counted");
  ack_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_wait_acknowledge |-> $past(host_access_req))
    else $error("wait acknowledge without host access");
  lane_own_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MCMC_RUN && !los[1] |=> recovered_rx_clock[1] == $past(line_rx_clock[1])
      && rx_positive_rail[1] == $past(rec_pos[1]))
    else $error("channel output not from its own sources");

  down_c: cover property (@(posedge clk) disable iff (!rst_n) mode == MCMC_DOWN ##1 mode == MCMC_RUN);
  raw_c: cover property (@(posedge clk) disable iff (!rst_n) mode == MCMC_RAW ##1 mode == MCMC_RUN);
  ack_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(host_wait_acknowledge));
  los_c: cover property (@(posedge clk) disable iff (!rst_n) los[0] && all_ones_tx_generator_en[0] && ref_rise);
endmodule
`default_nettype wire

// ==== bench/mcmc_ref_model.sv ====
// Board reference clock source model for the master clock mode control bench
`timescale 1ns/10ps
`default_nettype none
module mcmc_ref_model #(
  parameter int HALF_CYC = 49
) (
  input wire logic clk,
  input wire logic [1:0] hold,
  output logic master_ref_clock
);
  int cnt = 0;
  logic level = 1'b0;
  assign master_ref_clock = level;
  // Moves on the falling edge so the block never samples it mid-change
  always @(negedge clk) begin
    if (hold == 2'h1) begin
      level <= 1'b0;
    end else if (hold == 2'h2) begin
      level <= 1'b1;
    end else if (cnt == HALF_CYC - 1) begin
      level <= ~level;
    end
    cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
  end
endmodule
`default_nettype wire

// ==== bench/mcmc_top_tb_top.sv ====
// Self-checking bench for the master clock mode control block
`timescale 1ns/10ps
`default_nettype none
module mcmc_top_tb_top
  import mcmc_pkg::*;
;
  logic clk, rst_n, master_ref_clock, host_access_req;
  logic [1:0] hold;
  logic [NUM_CH-1:0] los, all_ones_tx_generator_en, tx_clock_in, line_rx_clock, rec_pos, rec_neg, raw_pos, raw_neg;
  logic [NUM_CH-1:0] recovered_rx_clock, rx_positive_rail, rx_negative_rail, rx_oe, all_ones_tx_generator;
  logic ref_timing_tick, clock_recovery_enable, rx_path_powered, host_wait_acknowledge;
  int fail_count = 0;
  int n_compared = 0;

  mcmc_top u_mcmc_top (.clk, .rst_n, .master_ref_clock, .los, .all_ones_tx_generator_en, .tx_clock_in, .line_rx_clock,
    .rec_pos, .rec_neg, .raw_pos, .raw_neg, .host_access_req, .recovered_rx_clock, .rx_positive_rail,
    .rx_negative_rail, .rx_oe, .all_ones_tx_generator, .ref_timing_tick, .clock_recovery_enable,
    .rx_path_powered, .host_wait_acknowledge);
  mcmc_ref_model u_mcmc_ref_model (.clk, .hold, .master_ref_clock);

  // ==========================================================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_run();
    rec_pos = 8'h5a;
    rec_neg = 8'ha5;
    line_rx_clock = 8'h3c;
    cyc(2);
    chk(rx_positive_rail, 8'h5a, "pos rail");
    chk(rx_negative_rail, 8'ha5, "neg rail");
    chk(recovered_rx_clock, 8'h3c, "rx clock");
    chk({5'h00, clock_recovery_enable, rx_path_powered, host_wait_acknowledge}, 8'h06, "run");
  endtask
  task automatic t_los();
    los = 8'h81;
    line_rx_clock = 8'h00;
    @(posedge master_ref_clock);
    cyc(4);
    chk(recovered_rx_clock, 8'h81, "los high");
    @(negedge master_ref_clock);
    cyc(4);
    chk(recovered_rx_clock, 8'h00, "los low");
    los = 8'h00;
  endtask
  task automatic t_all_ones_tx_generator();
    int c0, c1, tk;
    c0 = 0;
    c1 = 0;
    tk = 0;
    all_ones_tx_generator_en = 8'h01;
    @(posedge master_ref_clock);
    cyc(8);
    // Transmit clock edges inside a reference gap must not reach channel 0
    for (int i = 0; i < 28; i++) begin
      c0 += all_ones_tx_generator[0];
      c1 += all_ones_tx_generator[1];
      if (i < 24) tx_clock_in = tx_clock_in ^ 8'h03;
      cyc(1);
    end
    chk(c0[7:0], 8'h00, "alarm ignores tx clock");
    chk(c1[7:0], 8'h0c, "tx clock pulses");
    c0 = 0;
    @(posedge master_ref_clock);
    for (int i = 0; i < 10; i++) begin
      c0 += all_ones_tx_generator[0];
      tk += ref_timing_tick;
      cyc(1);
    end
    chk(c0[7:0], 8'h01, "alarm from reference");
    chk(tk[7:0], 8'h01, "reference tick");
    all_ones_tx_generator_en = 8'h00;
  endtask
  task automatic t_host();
    int r;
    logic p;
    r = 0;
    @(posedge master_ref_clock);
    cyc(5);
    p = master_ref_clock;
    host_access_req = 1'b1;
    for (int i = 0; i < 400 && host_wait_acknowledge !== 1'b1; i++) begin
      cyc(1);
      if (master_ref_clock && !p) r++;
      p = master_ref_clock;
    end
    chk(r[7:0], 8'h02, "reference rises to ack");
    host_access_req = 1'b0;
    cyc(2);
    chk({7'h00, host_wait_acknowledge}, 8'h00, "ack drop");
  endtask
  task automatic t_low();
    hold = 2'h1;
    host_access_req = 1'b1;
    cyc(300);
    chk(rx_oe, 8'hff, "early static");
    cyc(120);
    chk(rx_oe, 8'h00, "down enable");
    chk(rx_positive_rail | rx_negative_rail | recovered_rx_clock, 8'h00, "down outputs");
    chk({5'h00, clock_recovery_enable, rx_path_powered, host_wait_acknowledge}, 8'h00, "down");
    host_access_req = 1'b0;
    hold = 2'h0;
    cyc(60);
    chk(rx_oe, 8'hff, "leave static");
  endtask
  task automatic t_high();
    raw_pos = 8'hc3;
    raw_neg = 8'h3c;
    hold = 2'h2;
    cyc(420);
    chk(rx_positive_rail, 8'hc3, "raw pos");
    chk(rx_negative_rail, 8'h3c, "raw neg");
    chk(recovered_rx_clock, 8'h00, "raw clock");
    chk({rx_oe[6:0], clock_recovery_enable}, 8'hfe, "raw mode");
    hold = 2'h0;
    cyc(60);
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    rst_n = 1'b0;
    hold = 2'h0;
    host_access_req = 1'b0;
    {los, all_ones_tx_generator_en, tx_clock_in, line_rx_clock, rec_pos, rec_neg, raw_pos, raw_neg} = '0;
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    t_run();
    t_los();
    t_all_ones_tx_generator();
    t_host();
    t_low();
    t_high();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
